// >>> vin_cfg_params.svh
// constants for the input threshold and fault configuration block
// ---------------------------------------------------------------
// How it works
// - turn-on word has exponent -2, default 18, accepts 17 to 31
// - written turn-off value is rounded to the nearest 0.25 V step
// - out-of-range turn-off write keeps old value, flags error, raises alert
// - writes leaving turn-on not above turn-off are rejected with flags and alert
// - turn-off default 16, accepts 16 to 30, exponent fixed at -2
// - turn-off word is 5-bit exponent, 11-bit mantissa, top four bits fixed
// - calibration offset, default zero, corrects reported current and fault limits
// - offset is 62.5 mA steps from +3.9375 A to -4 A, out-of-range aliases
// - offset exponent -4, writable sign, sign copies, six writable low bits
// - thresholds, offset and overvoltage action are copied on store-all command
// - overvoltage fault sets byte, word and output flags and raises alert
// - as loop follower, overvoltage action access is refused, reports invalid command
// - default overvoltage action shuts down and restarts after seven rise periods
// - select bit 0 keeps running with flags; 1 shuts down, and retries only with retry code 111
// - only retry codes 000 and 111 accepted; others rejected with flags
// - delay bits read as copies of top retry bit; 111 waits seven periods
// ---------------------------------------------------------------
`ifndef VIN_CFG_PARAMS_SVH
`define VIN_CFG_PARAMS_SVH

// command codes
`define CMD_CLEAR_STATUS 8'h03
`define CMD_STORE_ALL 8'h11
`define CMD_VIN_ON 8'h35
`define CMD_INPUT_STOP_THRESHOLD 8'h36
`define CMD_CAL_OFFSET 8'h39
`define CMD_OV_ACTION 8'h41

// threshold words, counts of 0.25 V
`define THR_EXP 5'h1E
`define VIN_ON_RESET 7'h12
`define VIN_ON_MIN 7'h11
`define VIN_ON_MAX 7'h1F
`define INPUT_STOP_THRESHOLD_RESET 7'h10
`define INPUT_STOP_THRESHOLD_MIN 7'h10
`define INPUT_STOP_THRESHOLD_MAX 7'h1E

// calibration offset word, counts of 62.5 mA
`define CAL_EXP 5'h1C
`define CAL_SIGN_BIT 10
`define CAL_LOW_MSB 5

// overvoltage action byte
`define OV_SEL_BIT 7
`define OV_RETRY_MSB 5
`define OV_RETRY_LSB 3
`define OV_SEL_RESET 1'b1
`define OV_RETRY_RESET 1'b1
`define RETRY_PERIODS 3'h7

`endif

// >>> vin_cfg_pkg.sv
// types shared by the input threshold and fault configuration block
`default_nettype none

package vin_cfg_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic nack;
        logic [15:0] data;
    } rsp_t;

    typedef struct packed {
        logic cml;
        logic invalid_data;
        logic invalid_command_fault;
        logic overvoltage_flag;
        logic output_voltage_word_flag;
        logic vout_overvoltage_flag;
    } status_t;

    typedef struct packed {
        logic [6:0] vin_on;
        logic [6:0] input_stop_threshold;
        logic [6:0] cal_offset;
        logic response_select;
        logic retry_setting;
    } nvm_image_t;

    typedef enum logic [1:0] {
        CONV_RUN,
        CONV_LATCHED,
        CONV_WAIT
    } conv_state_t;

endpackage

`default_nettype wire

// >>> vin_cfg.sv
// threshold, calibration offset and overvoltage action configuration
`timescale 1ns/1ps
`default_nettype none
`include "vin_cfg_params.svh"

module vin_cfg (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // decoded command port and its answer
    input wire vin_cfg_pkg::cmd_t cmd_i,
    output vin_cfg_pkg::rsp_t rsp_o,
    // device context and fault events
    input wire logic loop_follower_i,
    input wire logic ov_fault_i,
    input wire logic rise_period_tick_i,
    // status and alert
    output vin_cfg_pkg::status_t status_o,
    output logic alert_n_o,
    // converter control
    output logic conv_enable_o,
    output logic soft_start_o,
    // stored settings
    output logic [6:0] vin_on_counts_o,
    output logic [6:0] input_stop_threshold_counts_o,
    output logic nvm_store_o,
    output vin_cfg_pkg::nvm_image_t nvm_image_o,
    // current correction, signed counts of 62.5 mA
    input wire logic signed [11:0] iout_raw_i,
    input wire logic signed [11:0] oc_fault_limit_i,
    input wire logic signed [11:0] oc_warn_limit_i,
    output logic signed [11:0] iout_corr_o,
    output logic signed [11:0] oc_fault_limit_corr_o,
    output logic signed [11:0] oc_warn_limit_corr_o
);
    import vin_cfg_pkg::*;

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // converts any linear word to 0.25 V counts, rounding to nearest;
    // negative or huge values saturate so the range check rejects them
    function automatic logic [6:0] quarter_counts(input logic [15:0] w);
        logic signed [5:0] sh;
        logic [17:0] v;
        logic [4:0] rs;
        sh = $signed({w[15], w[15:11]}) + 6'sh02;
        rs = 5'(-sh);
        if (w[10]) begin
            v = 18'h00000;
        end else if (sh >= 6'sh00) begin
            v = (sh > 6'sh06) ? 18'h3FFFF : 18'({7'h00, w[10:0]} << sh[2:0]);
        end else begin
            v = 18'(({7'h00, w[10:0]} + (18'h00001 << (rs - 5'h01))) >> rs);
        end
        quarter_counts = (v > 18'h0007F) ? 7'h7F : v[6:0];
    endfunction

    function automatic logic known_code(input logic [7:0] c);
        known_code = (c == `CMD_CLEAR_STATUS) || (c == `CMD_STORE_ALL) || (c == `CMD_VIN_ON) ||
                     (c == `CMD_INPUT_STOP_THRESHOLD) || (c == `CMD_CAL_OFFSET) || (c == `CMD_OV_ACTION);
    endfunction

    // ---------------------------------------------------------------
    // command classification
    // ---------------------------------------------------------------
    logic [6:0] wr_q;
    logic refused;
    logic wr_on;
    logic wr_off;
    logic wr_cal;
    logic wr_ov;
    logic on_bad;
    logic off_bad;
    logic ov_bad;
    logic clear_req;
    logic store_req;

    assign wr_q = quarter_counts(cmd_i.data);

    always_comb begin
        refused = cmd_i.valid && (!known_code(cmd_i.code) ||
                  (loop_follower_i && cmd_i.code == `CMD_OV_ACTION));
        wr_on = cmd_i.valid && cmd_i.write && !refused && cmd_i.code == `CMD_VIN_ON;
        wr_off = cmd_i.valid && cmd_i.write && !refused && cmd_i.code == `CMD_INPUT_STOP_THRESHOLD;
        wr_cal = cmd_i.valid && cmd_i.write && !refused && cmd_i.code == `CMD_CAL_OFFSET;
        wr_ov = cmd_i.valid && cmd_i.write && !refused && cmd_i.code == `CMD_OV_ACTION;
        clear_req = cmd_i.valid && cmd_i.write && cmd_i.code == `CMD_CLEAR_STATUS;
        store_req = cmd_i.valid && cmd_i.write && cmd_i.code == `CMD_STORE_ALL;
        on_bad = wr_on && (wr_q < `VIN_ON_MIN || wr_q > `VIN_ON_MAX || wr_q <= input_stop_threshold_counts_o);
        off_bad = wr_off && (wr_q < `INPUT_STOP_THRESHOLD_MIN || wr_q > `INPUT_STOP_THRESHOLD_MAX || wr_q >= vin_on_counts_o);
        ov_bad = wr_ov && cmd_i.data[`OV_RETRY_MSB:`OV_RETRY_LSB] != 3'h0 &&
                 cmd_i.data[`OV_RETRY_MSB:`OV_RETRY_LSB] != 3'h7;
    end

    // ---------------------------------------------------------------
    // stored settings
    // ---------------------------------------------------------------
    logic cal_sign_r;
    logic [5:0] cal_low_r;
    logic ov_sel_r;
    logic ov_retry_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            vin_on_counts_o <= `VIN_ON_RESET;
            input_stop_threshold_counts_o <= `INPUT_STOP_THRESHOLD_RESET;
        end else begin
            if (wr_on && !on_bad) begin
                vin_on_counts_o <= wr_q;
            end
            if (wr_off && !off_bad) begin
                input_stop_threshold_counts_o <= wr_q;
            end
        end
    end

    // only sign and low six bits are kept, so wider values alias
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cal_sign_r <= 1'b0;
            cal_low_r <= 6'h00;
        end else if (wr_cal) begin
            cal_sign_r <= cmd_i.data[`CAL_SIGN_BIT];
            cal_low_r <= cmd_i.data[`CAL_LOW_MSB:0];
        end
    end

    // three equal retry bits mean one stored bit
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ov_sel_r <= `OV_SEL_RESET;
            ov_retry_r <= `OV_RETRY_RESET;
        end else if (wr_ov && !ov_bad) begin
            ov_sel_r <= cmd_i.data[`OV_SEL_BIT];
            ov_retry_r <= cmd_i.data[`OV_RETRY_MSB];
        end
    end

    // ---------------------------------------------------------------
    // command answer
    // ---------------------------------------------------------------
    logic [15:0] rd_data;

    always_comb begin
        unique case (cmd_i.code)
            `CMD_VIN_ON: rd_data = {`THR_EXP, 4'h0, vin_on_counts_o};
            `CMD_INPUT_STOP_THRESHOLD: rd_data = {`THR_EXP, 4'h0, input_stop_threshold_counts_o};
            `CMD_CAL_OFFSET: rd_data = {`CAL_EXP, cal_sign_r, {4{cal_sign_r}}, cal_low_r};
            `CMD_OV_ACTION: rd_data = {8'h00, ov_sel_r, 1'b0, {3{ov_retry_r}}, {3{ov_retry_r}}};
            default: rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= cmd_i.valid;
            rsp_o.nack <= refused;
            rsp_o.data <= (cmd_i.valid && !cmd_i.write && !refused) ? rd_data : 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // status flags and alert
    // ---------------------------------------------------------------
    logic bad_data;

    assign bad_data = on_bad || off_bad || ov_bad;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            status_o <= '0;
        end else begin
            status_o.cml <= bad_data || (status_o.cml && !clear_req);
            status_o.invalid_data <= bad_data || (status_o.invalid_data && !clear_req);
            status_o.invalid_command_fault <= refused || (status_o.invalid_command_fault && !clear_req);
            status_o.overvoltage_flag <= ov_fault_i || (status_o.overvoltage_flag && !clear_req);
            status_o.output_voltage_word_flag <= ov_fault_i ||
                (status_o.output_voltage_word_flag && !clear_req);
            status_o.vout_overvoltage_flag <= ov_fault_i || (status_o.vout_overvoltage_flag && !clear_req);
        end
    end

    // one cycle behind the flags; the pin is open drain outside
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            alert_n_o <= 1'b1;
        end else begin
            alert_n_o <= ~|status_o;
        end
    end

    // ---------------------------------------------------------------
    // overvoltage response sequencing
    // ---------------------------------------------------------------
    conv_state_t state_r;
    logic [2:0] period_cnt_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= CONV_RUN;
            period_cnt_r <= 3'h0;
            conv_enable_o <= 1'b1;
            soft_start_o <= 1'b0;
        end else begin
            soft_start_o <= 1'b0;
            unique case (state_r)
                CONV_RUN: begin
                    if (ov_fault_i && ov_sel_r) begin
                        conv_enable_o <= 1'b0;
                        period_cnt_r <= 3'h0;
                        state_r <= ov_retry_r ? CONV_WAIT : CONV_LATCHED;
                    end
                end
                CONV_LATCHED: begin
                    if (clear_req) begin
                        conv_enable_o <= 1'b1;
                        soft_start_o <= 1'b1;
                        state_r <= CONV_RUN;
                    end
                end
                CONV_WAIT: begin
                    if (rise_period_tick_i) begin
                        if (period_cnt_r == `RETRY_PERIODS - 3'h1) begin
                            conv_enable_o <= 1'b1;
                            soft_start_o <= 1'b1;
                            state_r <= CONV_RUN;
                        end else begin
                            period_cnt_r <= period_cnt_r + 3'h1;
                        end
                    end
                end
                default: state_r <= CONV_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // nonvolatile copy and current correction
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            nvm_store_o <= 1'b0;
            nvm_image_o <= '0;
        end else begin
            nvm_store_o <= store_req;
            if (store_req) begin
                nvm_image_o <= {vin_on_counts_o, input_stop_threshold_counts_o, cal_sign_r, cal_low_r, ov_sel_r, ov_retry_r};
            end
        end
    end

    logic signed [11:0] cal_value;

    assign cal_value = $signed({{6{cal_sign_r}}, cal_low_r});

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            iout_corr_o <= 12'sh000;
            oc_fault_limit_corr_o <= 12'sh000;
            oc_warn_limit_corr_o <= 12'sh000;
        end else begin
            iout_corr_o <= iout_raw_i + cal_value;
            oc_fault_limit_corr_o <= oc_fault_limit_i + cal_value;
            oc_warn_limit_corr_o <= oc_warn_limit_i + cal_value;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_off_range_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        wr_off && (wr_q < `INPUT_STOP_THRESHOLD_MIN || wr_q > `INPUT_STOP_THRESHOLD_MAX) |=> $stable(input_stop_threshold_counts_o) && status_o.cml)
        else $error("out-of-range turn-off write changed value or left no flag");
    a_on_above_off: assert property (@(posedge clk_i) disable iff (reset_i)
        vin_on_counts_o > input_stop_threshold_counts_o)
        else $error("turn-on threshold not above turn-off");
    a_cal_readback: assert property (@(posedge clk_i) disable iff (reset_i)
        cmd_i.valid && !cmd_i.write && cmd_i.code == `CMD_CAL_OFFSET |=>
        rsp_o.data[15:11] == `CAL_EXP && rsp_o.data[9:6] == {4{rsp_o.data[10]}})
        else $error("offset readback fixed bits wrong");
    a_ov_flags_set: assert property (@(posedge clk_i) disable iff (reset_i)
        ov_fault_i |=> status_o.overvoltage_flag && status_o.output_voltage_word_flag ##1 !alert_n_o)
        else $error("overvoltage fault flags or alert missing");
    a_follower_nack: assert property (@(posedge clk_i) disable iff (reset_i)
        cmd_i.valid && loop_follower_i && cmd_i.code == `CMD_OV_ACTION |=>
        rsp_o.nack && status_o.invalid_command_fault && $stable(ov_sel_r))
        else $error("follower access to overvoltage action not refused");
    a_ignore_keeps_run: assert property (@(posedge clk_i) disable iff (reset_i)
        state_r == CONV_RUN && ov_fault_i && !ov_sel_r |=> conv_enable_o && state_r == CONV_RUN)
        else $error("ignore mode shut the converter down");
    a_retry_reject: assert property (@(posedge clk_i) disable iff (reset_i)
        ov_bad |=> $stable(ov_retry_r) && status_o.invalid_data)
        else $error("bad retry code accepted");
    a_store_pulse: assert property (@(posedge clk_i) disable iff (reset_i)
        store_req && !$past(store_req) |=> nvm_store_o && nvm_image_o.input_stop_threshold == $past(input_stop_threshold_counts_o))
        else $error("store-all did not copy settings");
    a_restart_source: assert property (@(posedge clk_i) disable iff (reset_i)
        soft_start_o |-> $past(state_r) != CONV_RUN && conv_enable_o)
        else $error("soft start without prior shutdown");

endmodule // vin_cfg

`default_nettype wire

// >>> pmbus_host_model.sv
// host side model that issues decoded commands and collects answers
`timescale 1ns/1ps
`default_nettype none

module pmbus_host_model (
    // clock
    input wire logic clk_i,
    // command out, answer in
    output vin_cfg_pkg::cmd_t cmd_o,
    input wire vin_cfg_pkg::rsp_t rsp_i
);
    import vin_cfg_pkg::*;

    initial cmd_o = '0;

    // one command pulse, answer taken one edge later
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output rsp_t r);
        @(posedge clk_i);
        #1 cmd_o = {1'b1, w, c, d};
        @(posedge clk_i);
        #1 r = rsp_i;
        // idle port shows inverted fields, never a stale copy
        cmd_o = {1'b0, ~w, ~c, ~d};
    endtask
endmodule // pmbus_host_model

`default_nettype wire

// >>> vin_cfg_tb.sv
// self-checking bench for the threshold and overvoltage configuration block
`timescale 1ns/1ps
`default_nettype none

module vin_cfg_tb;
    import vin_cfg_pkg::*;
    typedef struct packed {
        logic w;
        logic [7:0] code;
        logic [15:0] data;
        logic nack;
        logic [15:0] rdata;
        logic [6:0] on;
        logic [6:0] off;
        logic [5:0] st;
    } row_t;
    logic clk_i, reset_i, follower, ov_fault, tick, alert_n, conv_en, soft_start, nvm_store;
    cmd_t cmd;
    rsp_t rsp, r;
    status_t status;
    nvm_image_t nvm_image;
    logic [6:0] vin_on, input_stop_threshold;
    logic signed [11:0] iout_corr, fault_corr, warn_corr;
    int n_errors = 0;
    int checks = 0;
    int k;
    // w code data | nack rdata on off status
    row_t rows [28] = '{
        '{1'b0, 8'h36, 16'h0000, 1'b0, 16'hF010, 7'h12, 7'h10, 6'h00},
        '{1'b0, 8'h35, 16'h0000, 1'b0, 16'hF012, 7'h12, 7'h10, 6'h00},
        '{1'b0, 8'h41, 16'h0000, 1'b0, 16'h00BF, 7'h12, 7'h10, 6'h00},
        '{1'b1, 8'h36, 16'hF011, 1'b0, 16'h0000, 7'h12, 7'h11, 6'h00},
        '{1'b1, 8'h36, 16'hF020, 1'b0, 16'h0000, 7'h12, 7'h11, 6'h30},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h12, 7'h11, 6'h00},
        '{1'b1, 8'h35, 16'hF01F, 1'b0, 16'h0000, 7'h1F, 7'h11, 6'h00},
        '{1'b1, 8'h36, 16'hF01E, 1'b0, 16'h0000, 7'h1F, 7'h1E, 6'h00},
        '{1'b1, 8'h35, 16'hF01E, 1'b0, 16'h0000, 7'h1F, 7'h1E, 6'h30},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h1F, 7'h1E, 6'h00},
        '{1'b1, 8'h36, 16'hF010, 1'b0, 16'h0000, 7'h1F, 7'h10, 6'h00},
        '{1'b1, 8'h35, 16'hF011, 1'b0, 16'h0000, 7'h11, 7'h10, 6'h00},
        '{1'b1, 8'h36, 16'hF011, 1'b0, 16'h0000, 7'h11, 7'h10, 6'h30},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h11, 7'h10, 6'h00},
        '{1'b1, 8'h35, 16'hF010, 1'b0, 16'h0000, 7'h11, 7'h10, 6'h30},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h11, 7'h10, 6'h00},
        '{1'b1, 8'h35, 16'hE825, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00},
        '{1'b0, 8'h39, 16'h0000, 1'b0, 16'hE000, 7'h13, 7'h10, 6'h00},
        '{1'b1, 8'h39, 16'hE445, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00},
        '{1'b0, 8'h39, 16'h0000, 1'b0, 16'hE7C5, 7'h13, 7'h10, 6'h00},
        '{1'b1, 8'h41, 16'h0090, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h30},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00},
        '{1'b1, 8'h41, 16'h0080, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00},
        '{1'b0, 8'h41, 16'h0000, 1'b0, 16'h0080, 7'h13, 7'h10, 6'h00},
        '{1'b1, 8'h41, 16'h00B8, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00},
        '{1'b0, 8'h41, 16'h0000, 1'b0, 16'h00BF, 7'h13, 7'h10, 6'h00},
        '{1'b0, 8'h7A, 16'h0000, 1'b1, 16'h0000, 7'h13, 7'h10, 6'h08},
        '{1'b1, 8'h03, 16'h0000, 1'b0, 16'h0000, 7'h13, 7'h10, 6'h00}};

    // --------------------------------
    // clock, design and host model
    // --------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    vin_cfg u_vin_cfg (.clk_i(clk_i), .reset_i(reset_i), .cmd_i(cmd), .rsp_o(rsp),
        .loop_follower_i(follower), .ov_fault_i(ov_fault), .rise_period_tick_i(tick),
        .status_o(status), .alert_n_o(alert_n), .conv_enable_o(conv_en), .soft_start_o(soft_start),
        .vin_on_counts_o(vin_on), .input_stop_threshold_counts_o(input_stop_threshold), .nvm_store_o(nvm_store),
        .nvm_image_o(nvm_image), .iout_raw_i(12'sh064), .oc_fault_limit_i(12'sh0C8),
        .oc_warn_limit_i(12'shFF6), .iout_corr_o(iout_corr), .oc_fault_limit_corr_o(fault_corr),
        .oc_warn_limit_corr_o(warn_corr));

    pmbus_host_model u_pmbus_host_model (.clk_i(clk_i), .cmd_o(cmd), .rsp_i(rsp));

    // --------------------------------
    // helpers
    // --------------------------------
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic pulse_fault();
        @(posedge clk_i);
        #1 ov_fault = 1'b1;
        @(posedge clk_i);
        #1 ov_fault = 1'b0;
    endtask

    // a period tick every other cycle keeps pulses one cycle wide
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1 tick = 1'b1;
            @(posedge clk_i);
            #1 tick = 1'b0;
        end
    endtask

    task automatic wait_run();
        for (k = 0; k < 3 && conv_en !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
    endtask

    // --------------------------------
    // tests
    // --------------------------------
    initial begin
        #100000;
        n_errors++;
        summarize();
    end

    initial begin
        reset_i = 1'b1;
        follower = 1'b0;
        ov_fault = 1'b0;
        tick = 1'b0;
        repeat (8) @(posedge clk_i);
        #1 reset_i = 1'b0;
        foreach (rows[i]) begin
            u_pmbus_host_model.xfer(rows[i].w, rows[i].code, rows[i].data, r);
            check(r.valid, 1'b1);
            check(r.nack, rows[i].nack);
            check(r.data, rows[i].rdata);
            check(vin_on, rows[i].on);
            check(input_stop_threshold, rows[i].off);
            check(status, rows[i].st);
            @(posedge clk_i);
            #1 check(alert_n, rows[i].st == 6'h00);
        end
        check(iout_corr, 12'h029);
        check(fault_corr, 12'h08D);
        check($unsigned(warn_corr), 12'hFBB);
        u_pmbus_host_model.xfer(1'b1, 8'h11, 16'h0000, r);
        for (k = 0; k < 3 && nvm_store !== 1'b1; k++) begin
            @(posedge clk_i);
            #1;
        end
        check(nvm_store, 1'b1);
        check(nvm_image, {7'h13, 7'h10, 7'h45, 1'b1, 1'b1});
        // default-style restart after seven periods
        pulse_fault();
        check(conv_en, 1'b0);
        check(status, 6'h07);
        @(posedge clk_i);
        #1 check(alert_n, 1'b0);
        ticks(6);
        repeat (2) @(posedge clk_i);
        #1 check(conv_en, 1'b0);
        ticks(1);
        wait_run();
        check(conv_en, 1'b1);
        check(soft_start, 1'b1);
        // retry off: stays down until cleared
        u_pmbus_host_model.xfer(1'b1, 8'h41, 16'h0080, r);
        pulse_fault();
        ticks(8);
        check(conv_en, 1'b0);
        u_pmbus_host_model.xfer(1'b1, 8'h03, 16'h0000, r);
        wait_run();
        check(conv_en, 1'b1);
        // ignore mode keeps running but flags
        u_pmbus_host_model.xfer(1'b1, 8'h41, 16'h0038, r);
        pulse_fault();
        check(conv_en, 1'b1);
        check(status, 6'h07);
        // loop follower: access refused, write ignored
        follower = 1'b1;
        u_pmbus_host_model.xfer(1'b0, 8'h41, 16'h0000, r);
        check(r.nack, 1'b1);
        check(status, 6'h0F);
        u_pmbus_host_model.xfer(1'b1, 8'h41, 16'h0080, r);
        check(r.nack, 1'b1);
        follower = 1'b0;
        u_pmbus_host_model.xfer(1'b0, 8'h41, 16'h0000, r);
        check(r.data, 16'h003F);
        // turn-off word in eighths, halfway value rounds up to 4.5 V
        u_pmbus_host_model.xfer(1'b1, 8'h36, 16'hE823, r);
        check(input_stop_threshold, 7'h12);
        // reset in mid run restores defaults
        @(posedge clk_i);
        #1 reset_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 reset_i = 1'b0;
        check({vin_on, input_stop_threshold}, {7'h12, 7'h10});
        check({status, alert_n, conv_en}, 8'h03);
        u_pmbus_host_model.xfer(1'b0, 8'h39, 16'h0000, r);
        check(r.data, 16'hE000);
        check(iout_corr, 12'h064);
        summarize();
    end
endmodule // vin_cfg_tb

`default_nettype wire
